// ==== common/lockctl_pkg.sv ====
// shared constants and carrier types for the write lock and soft reset control block
package lockctl_pkg;

    // ==========================================
    // register map
    localparam logic [7:0] LOCK_REG_ADDR     = 8'h10;  // write_lock_reset_control
    localparam logic [7:0] SUPPLY_STATUS_ADDR = 8'h02; // supply_status_register, read clears supply errors in I2C mode or once the recovery timer has expired
    localparam logic [7:0] LOCK_REG_RESET    = 8'h00;  // value after any reset
    localparam int         INIT_DONE_BIT     = 7;      // init_done_lock
    localparam int         REPORT_DIS_BIT    = 3;      // supply_error_report_disable
    localparam logic [7:0] EDC_MASK          = 8'hfc;  // soft reset code bits left out of the error code

    // ==========================================
    // soft reset code steps, written as {bit1, bit0}
    localparam logic [1:0] SEQ_CODE_1 = 2'h0;
    localparam logic [1:0] SEQ_CODE_2 = 2'h3;
    localparam logic [1:0] SEQ_CODE_3 = 2'h2;

    // ==========================================
    // timing
    localparam int                CLK_PERIOD_NS           = 10;       // core clock period
    localparam int                SUPPLY_RECOVERY_TIME_NS = 1000000;  // supply_recovery_time
    localparam int                TIMER_W                 = 24;
    localparam logic [TIMER_W-1:0] RECOVERY_CYCLES =
        TIMER_W'(SUPPLY_RECOVERY_TIME_NS / CLK_PERIOD_NS);

    // ==========================================
    // error detection code
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'hff;

    // ==========================================
    // carriers
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b001,  // no step seen
        SEQ_GOT1 = 3'b010,  // first step seen
        SEQ_GOT2 = 3'b100   // second step seen
    } seq_state_t;

    typedef struct packed {
        logic       write;  // 1 write, 0 read
        logic [7:0] addr;
        logic [7:0] data;
    } link_req_t;

    typedef struct packed {
        logic       silent;      // no response or no acknowledge
        logic       error_code;  // sensor data field error code in this response
        logic [7:0] data;
    } link_rsp_t;

    typedef struct packed {
        logic [1:0]         req_sync;   // request toggle synchroniser
        logic               req_seen;   // last toggle value handled
        logic               rsp_tgl;    // response toggle
        link_rsp_t          rsp;        // response holding word
        logic [1:0]         sup_sync;   // supply error pin synchroniser
        logic [1:0]         mode_sync;  // interface mode pin synchroniser
        logic [7:0]         lock_reg;   // write_lock_reset_control
        seq_state_t         seq;
        logic               soft_reset;
        logic               sup_err;
        logic [TIMER_W-1:0] timer;
        logic               selftest_run;
        logic               user_wr;
        logic [7:0]         user_addr;
        logic [7:0]         user_data;
    } core_state_t;

    typedef struct packed {
        logic       req_tgl;
        link_req_t  req;
        logic [1:0] rsp_sync;
        logic       rsp_seen;
        logic       rsp_valid;
        link_rsp_t  rsp;
    } link_state_t;

    typedef struct packed {
        logic       armed;
        logic [7:0] reference;
        logic       mismatch;
    } edc_state_t;

endpackage

// ==== logic/edc_checker.sv ====
// error detection code checker over the user writable registers
`timescale 1ns/10ps
module edc_checker #(
    parameter int DATA_W = 40
) (
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    input  wire logic              i_enable,   // checking runs while high
    input  wire logic [DATA_W-1:0] i_data,     // registers under watch
    output      logic              o_mismatch  // code differs from the reference
);

    // ==========================================
    // code computation
    function automatic logic [7:0] crc8(input logic [DATA_W-1:0] d);
        logic [7:0] c;
        logic       fb;
        c  = lockctl_pkg::CRC_INIT;
        fb = 1'b0;
        for (int i = DATA_W - 1; i >= 0; i--) begin
            fb = c[7] ^ d[i];
            c  = {c[6:0], 1'b0};
            if (fb) begin
                c = c ^ lockctl_pkg::CRC_POLY;
            end
        end
        return c;
    endfunction

    lockctl_pkg::edc_state_t cur;   // registered state
    lockctl_pkg::edc_state_t next;  // next state
    logic [7:0]              code;  // code of the present contents

    // ==========================================
    // reference capture and continuous compare
    always_comb begin
        next = cur;
        code = crc8(i_data);
        if (!i_enable) begin
            // idle until the lock is set
            next.armed    = 1'b0;
            next.mismatch = 1'b0;
        end else if (!cur.armed) begin
            // first code after locking becomes the reference
            next.armed     = 1'b1;
            next.reference = code;
        end else if (code != cur.reference) begin
            next.mismatch = 1'b1;
        end
    end

    // state register
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cur <= '0;
        end else begin
            cur <= next;
        end
    end

    assign o_mismatch = cur.mismatch;

    // ==========================================
    // checks
    AST_EDC_COMPARE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_enable && cur.armed && code != cur.reference) |=> o_mismatch)
        else $error("code change while locked not flagged");
    AST_EDC_IDLE_UNLOCKED: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !i_enable |=> (!cur.armed && !o_mismatch))
        else $error("checker active while unlocked");

endmodule // edc_checker

// ==== logic/write_lock_reset_ctrl.sv ====
// write lock, supply error reporting and soft reset control register
`timescale 1ns/10ps
module write_lock_reset_ctrl #(
    parameter logic [lockctl_pkg::TIMER_W-1:0] RECOVERY_CYCLES = lockctl_pkg::RECOVERY_CYCLES,
    parameter int                              USER_BYTES      = 4
) (
    input  wire logic                    I_CLK,            // core clock
    input  wire logic                    I_RESETN,         // asynchronous reset, active low
    input  wire logic                    I_LINK_CLK,       // serial front end clock
    input  wire logic                    I_REQ_VALID,      // link request strobe
    input  wire logic                    I_REQ_WRITE,      // 1 write, 0 read
    input  wire logic [7:0]              I_REQ_ADDR,       // register address
    input  wire logic [7:0]              I_REQ_DATA,       // write data
    output      logic                    O_REQ_READY,      // request may be taken
    output      logic                    O_RSP_VALID,      // response pulse, link clock
    output      logic                    O_RSP_SILENT,     // withhold the response or acknowledge
    output      logic                    O_RSP_ERROR_CODE, // send the sensor data field error code
    output      logic [7:0]              O_RSP_DATA,       // response data
    input  wire logic                    I_I2C_MODE,       // interface mode pin, 1 for I2C
    input  wire logic                    I_SUPPLY_ERR,     // supply monitor error pin
    input  wire logic                    I_SELFTEST_REQ,   // self-test request pulse
    input  wire logic                    I_SELFTEST_DONE,  // self-test finished pulse
    input  wire logic [USER_BYTES*8-1:0] I_USER_REGS,      // other user writable registers
    output      logic                    O_USER_WR,        // write to another register
    output      logic [7:0]              O_USER_ADDR,
    output      logic [7:0]              O_USER_DATA,
    output      logic                    O_INIT_DONE_LOCK, // lock state
    output      logic                    O_REPORT_DISABLE, // supply_error_report_disable
    output      logic                    O_SELFTEST_RUN,   // self-test running
    output      logic                    O_SUPPLY_ERR,     // supply error held
    output      logic                    O_EDC_ERR,        // user register corruption seen
    output      logic                    O_SOFT_RESET      // soft reset pulse
);

    // ==========================================
    // reset release, one copy per domain
    logic [1:0] rst_sync;       // core reset synchroniser
    logic [1:0] link_rst_sync;  // link reset synchroniser
    logic       rst_n;          // core reset, released in step with I_CLK
    logic       link_rst_n;     // link reset, released in step with I_LINK_CLK

    // core release
    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    // link release
    always_ff @(posedge I_LINK_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            link_rst_sync <= 2'h0;
        end else begin
            link_rst_sync <= {link_rst_sync[0], 1'b1};
        end
    end

    assign rst_n      = rst_sync[1];
    assign link_rst_n = link_rst_sync[1];

    // ==========================================
    // state
    lockctl_pkg::core_state_t cur;        // core registers
    lockctl_pkg::core_state_t next;       // core next values
    lockctl_pkg::link_state_t lcur;       // link registers
    lockctl_pkg::link_state_t lnext;      // link next values
    logic                     take;       // a new request reached the core
    logic                     locked;     // lock bit
    logic                     i2c;        // synchronised mode
    logic                     dis;        // report disable bit
    logic                     sup_now;    // synchronised supply error
    logic                     timer_zero; // recovery timer expired
    logic                     silent;     // responses withheld
    logic                     err_code;   // error code due in this response
    logic                     clear;      // supply error clear event
    logic                     fire;       // third step written
    logic [7:0]               new_reg;    // lock register after a write
    logic [1:0]               code;       // written reset code
    logic                     link_ready; // link idle

    // ==========================================
    // core logic
    always_comb begin
        next       = cur;
        locked     = cur.lock_reg[lockctl_pkg::INIT_DONE_BIT];
        dis        = cur.lock_reg[lockctl_pkg::REPORT_DIS_BIT];
        i2c        = cur.mode_sync[1];
        sup_now    = cur.sup_sync[1];
        timer_zero = (cur.timer == '0);
        take       = (cur.req_sync[1] != cur.req_seen);
        silent     = cur.sup_err && !timer_zero;
        err_code   = cur.sup_err && timer_zero && !i2c && !dis;
        clear      = 1'b0;
        fire       = 1'b0;
        new_reg    = cur.lock_reg;
        code       = lcur.req.data[1:0];
        // pin and toggle synchronisers
        next.req_sync  = {cur.req_sync[0], lcur.req_tgl};
        next.req_seen  = cur.req_sync[1];
        next.sup_sync  = {cur.sup_sync[0], I_SUPPLY_ERR};
        next.mode_sync = {cur.mode_sync[0], I_I2C_MODE};
        next.user_wr   = 1'b0;
        next.soft_reset = 1'b0;
        // recovery timer
        if (sup_now) begin
            next.timer = RECOVERY_CYCLES;
        end else if (!timer_zero) begin
            next.timer = cur.timer - 1'b1;
        end
        // self-test gate
        if (locked) begin
            next.selftest_run = 1'b0;
        end else if (I_SELFTEST_REQ) begin
            next.selftest_run = 1'b1;
        end else if (I_SELFTEST_DONE) begin
            next.selftest_run = 1'b0;
        end
        // request handling
        if (take) begin
            next.rsp_tgl        = ~cur.rsp_tgl;
            next.rsp.silent     = silent;
            next.rsp.error_code = err_code;
            next.rsp.data       = 8'h00;
            if (err_code) begin
                clear = 1'b1;
            end
            if (lcur.req.write) begin
                if (lcur.req.addr == lockctl_pkg::LOCK_REG_ADDR) begin
                    // only the code bits move once locked
                    if (locked) begin
                        new_reg = {cur.lock_reg[7:2], code};
                    end else begin
                        new_reg = {cur.lock_reg[7] | lcur.req.data[7], lcur.req.data[6:0]};
                    end
                    next.lock_reg = new_reg;
                    next.rsp.data = new_reg;
                    // code sequence
                    if (cur.seq == lockctl_pkg::SEQ_GOT2 && code == lockctl_pkg::SEQ_CODE_3) begin
                        fire            = 1'b1;
                        next.soft_reset = 1'b1;
                        next.seq        = lockctl_pkg::SEQ_IDLE;
                        next.rsp.silent = 1'b1;
                    end else if (cur.seq == lockctl_pkg::SEQ_GOT1 && code == lockctl_pkg::SEQ_CODE_2) begin
                        next.seq = lockctl_pkg::SEQ_GOT2;
                    end else if (code == lockctl_pkg::SEQ_CODE_1) begin
                        next.seq = lockctl_pkg::SEQ_GOT1;
                    end else begin
                        next.seq = lockctl_pkg::SEQ_IDLE;
                    end
                end else begin
                    // another register: sequence broken, write passed on only while unlocked
                    next.seq = lockctl_pkg::SEQ_IDLE;
                    if (!locked) begin
                        next.user_wr   = 1'b1;
                        next.user_addr = lcur.req.addr;
                        next.user_data = lcur.req.data;
                        next.rsp.data  = lcur.req.data;
                    end
                end
            end else begin
                // any read aborts the sequence
                next.seq = lockctl_pkg::SEQ_IDLE;
                if (lcur.req.addr == lockctl_pkg::LOCK_REG_ADDR) begin
                    next.rsp.data = {cur.lock_reg[7:2], 2'h0};
                end
                if (lcur.req.addr == lockctl_pkg::SUPPLY_STATUS_ADDR && (i2c || timer_zero)) begin
                    clear = 1'b1;
                end
            end
        end
        // automatic clear at expiry
        if (!i2c && dis && timer_zero) begin
            clear = 1'b1;
        end
        // a present error wins over any clear but the soft reset below
        next.sup_err = sup_now || (cur.sup_err && !clear);
        // soft reset clears lock, sequence, supply error and self-test; timer reloads if a supply error is present, else clears
        if (cur.soft_reset) begin
            next.lock_reg     = lockctl_pkg::LOCK_REG_RESET;
            next.seq          = lockctl_pkg::SEQ_IDLE;
            next.sup_err      = 1'b0;
            next.timer        = sup_now ? RECOVERY_CYCLES : '0;
            next.selftest_run = 1'b0;
        end
    end

    // core registers
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            cur          <= '0;
            cur.seq      <= lockctl_pkg::SEQ_IDLE;
            cur.lock_reg <= lockctl_pkg::LOCK_REG_RESET;
        end else begin
            cur <= next;
        end
    end

    // ==========================================
    // link side: request hold and response pulse
    always_comb begin
        lnext           = lcur;
        link_ready      = (lcur.req_tgl == lcur.rsp_seen);
        lnext.rsp_sync  = {lcur.rsp_sync[0], cur.rsp_tgl};
        lnext.rsp_seen  = lcur.rsp_sync[1];
        lnext.rsp_valid = (lcur.rsp_sync[1] != lcur.rsp_seen);
        // response word is quiet while its toggle settles
        if (lcur.rsp_sync[1] != lcur.rsp_seen) begin
            lnext.rsp = cur.rsp;
        end
        // hold the request until the core answers
        if (I_REQ_VALID && link_ready) begin
            lnext.req_tgl    = ~lcur.req_tgl;
            lnext.req.write  = I_REQ_WRITE;
            lnext.req.addr   = I_REQ_ADDR;
            lnext.req.data   = I_REQ_DATA;
        end
    end

    // link registers
    always_ff @(posedge I_LINK_CLK or negedge link_rst_n) begin
        if (!link_rst_n) begin
            lcur <= '0;
        end else begin
            lcur <= lnext;
        end
    end

    // ==========================================
    // corruption watch over user writable registers
    edc_checker #(
        .DATA_W (USER_BYTES * 8 + 8)
    ) u_edc (
        .i_clk      (I_CLK),
        .i_rst_n    (rst_n),
        .i_enable   (cur.lock_reg[lockctl_pkg::INIT_DONE_BIT]),
        .i_data     ({I_USER_REGS, cur.lock_reg & lockctl_pkg::EDC_MASK}),
        .o_mismatch (O_EDC_ERR)
    );

    // ==========================================
    // outputs
    assign O_REQ_READY      = link_ready;
    assign O_RSP_VALID      = lcur.rsp_valid;
    assign O_RSP_SILENT     = lcur.rsp.silent;
    assign O_RSP_ERROR_CODE = lcur.rsp.error_code;
    assign O_RSP_DATA       = lcur.rsp.data;
    assign O_USER_WR        = cur.user_wr;
    assign O_USER_ADDR      = cur.user_addr;
    assign O_USER_DATA      = cur.user_data;
    assign O_INIT_DONE_LOCK = cur.lock_reg[lockctl_pkg::INIT_DONE_BIT];
    assign O_REPORT_DISABLE = cur.lock_reg[lockctl_pkg::REPORT_DIS_BIT];
    assign O_SELFTEST_RUN   = cur.selftest_run;
    assign O_SUPPLY_ERR     = cur.sup_err;
    assign O_SOFT_RESET     = cur.soft_reset;

    // ==========================================
    // checks
    default clocking core_cb @(posedge I_CLK); endclocking
    default disable iff (!rst_n);

    AST_LOCK_STICKY: assert property ((locked && !cur.soft_reset) |=> O_INIT_DONE_LOCK)
        else $error("lock bit dropped without reset");
    AST_LOCKED_NO_USER_WR: assert property (locked |=> !O_USER_WR)
        else $error("user write passed while locked");
    AST_SELFTEST_OFF: assert property (locked |=> !O_SELFTEST_RUN)
        else $error("self-test running while locked");
    AST_THIRD_STEP_ONLY: assert property (O_SOFT_RESET |-> $past(cur.seq) == lockctl_pkg::SEQ_GOT2)
        else $error("soft reset without two prior steps");
    AST_RESET_SILENT: assert property (O_SOFT_RESET |-> (cur.rsp.silent && cur.rsp_tgl != $past(cur.rsp_tgl)))
        else $error("reset write was answered");
    AST_RESET_CLEARS: assert property (O_SOFT_RESET |=> (!O_INIT_DONE_LOCK && cur.seq == lockctl_pkg::SEQ_IDLE))
        else $error("soft reset left state behind");
    AST_READ_ZERO_CODE: assert property ((take && !lcur.req.write && lcur.req.addr == lockctl_pkg::LOCK_REG_ADDR)
        |=> (cur.rsp.data[1:0] == 2'h0 && cur.seq == lockctl_pkg::SEQ_IDLE))
        else $error("read showed code bits or kept sequence");
    AST_WRITE_ECHO: assert property ((take && lcur.req.write && !locked && !fire
        && lcur.req.addr == lockctl_pkg::LOCK_REG_ADDR) |=> cur.rsp.data == $past(lcur.req.data))
        else $error("write answer differs from written value");
    AST_TIMER_RELOAD: assert property (sup_now |=> cur.timer == RECOVERY_CYCLES)
        else $error("timer not reloaded on supply error");
    AST_SILENT_WHILE_TIMER: assert property ((take && cur.sup_err && !timer_zero) |=> cur.rsp.silent)
        else $error("response sent while timer running");
    AST_ERROR_CODE_ONCE: assert property ((take && err_code && !sup_now) |=> (cur.rsp.error_code && !O_SUPPLY_ERR))
        else $error("error code not sent once");
    AST_AUTO_CLEAR: assert property ((cur.sup_err && timer_zero && !i2c && dis && !sup_now && !cur.soft_reset)
        |=> !O_SUPPLY_ERR)
        else $error("supply error not cleared at expiry");
    AST_RSP_PULSE: assert property (@(posedge I_LINK_CLK) disable iff (!link_rst_n) O_RSP_VALID |=> !O_RSP_VALID)
        else $error("response strobe longer than one cycle");

    COV_SOFT_RESET: cover property (O_SOFT_RESET);
    COV_LOCK_SET: cover property ($rose(O_INIT_DONE_LOCK));
    COV_ERROR_CODE: cover property (take && err_code);
    COV_USER_WRITE: cover property (O_USER_WR);

endmodule // write_lock_reset_ctrl

// ==== test/lock_host_model.sv ====
// host side model that issues link requests one at a time
`timescale 1ns/10ps
module lock_host_model (
    input  wire logic                   i_clk,
    input  wire logic                   i_ready,
    input  wire logic                   i_rsp_valid,
    output      logic                   o_valid,
    output      lockctl_pkg::link_req_t o_req
);
    int missed = 0;  // requests left without an answer
    initial o_valid = 1'b0;
    initial o_req = '0;
    // ==========================================
    // request task: hold until ready is seen high at an edge, then wait for the answer
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge i_clk);
        o_valid <= 1'b1;
        o_req   <= '{w, a, d};
        do begin
            @(posedge i_clk);
        end while (!i_ready);
        o_valid <= 1'b0;
        o_req   <= ~o_req;  // released lines never show the stale value
        n = 0;
        do begin
            @(posedge i_clk);
            #1;
            n++;
        end while (!i_rsp_valid && n < 40);
        if (!i_rsp_valid) begin
            missed++;
        end
    endtask
endmodule // lock_host_model

// ==== test/write_lock_reset_ctrl_tb.sv ====
// self-checking bench for the write lock and soft reset control block
`timescale 1ns/10ps
module write_lock_reset_ctrl_tb;
    logic                  clk, lclk, rst_n, i2c, sup, st_req, st_done, valid, rv, silent, ecode;
    logic                  lock, rdis, strun, serr, edc, rdy, uwr, srst;
    logic [31:0]           user;
    logic [7:0]            rdata, uaddr, udata;
    lockctl_pkg::link_req_t req;
    int                    n_errors, total_checks, cyc, n_uwr, n_srst;
    // ==========================================
    // clocks, link clock unrelated in phase
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        lclk = 1'b0;
        #3;
        forever #7.5 lclk = ~lclk;
    end
    lock_host_model host (.i_clk(lclk), .i_ready(rdy), .i_rsp_valid(rv), .o_valid(valid), .o_req(req));
    write_lock_reset_ctrl #(.RECOVERY_CYCLES(24'd20), .USER_BYTES(4)) dut (
        .I_CLK(clk), .I_RESETN(rst_n), .I_LINK_CLK(lclk), .I_REQ_VALID(valid),
        .I_REQ_WRITE(req.write), .I_REQ_ADDR(req.addr), .I_REQ_DATA(req.data), .O_REQ_READY(rdy),
        .O_RSP_VALID(rv), .O_RSP_SILENT(silent), .O_RSP_ERROR_CODE(ecode), .O_RSP_DATA(rdata),
        .I_I2C_MODE(i2c), .I_SUPPLY_ERR(sup), .I_SELFTEST_REQ(st_req), .I_SELFTEST_DONE(st_done),
        .I_USER_REGS(user), .O_USER_WR(uwr), .O_USER_ADDR(uaddr), .O_USER_DATA(udata), .O_INIT_DONE_LOCK(lock),
        .O_REPORT_DISABLE(rdis), .O_SELFTEST_RUN(strun), .O_SUPPLY_ERR(serr), .O_EDC_ERR(edc),
        .O_SOFT_RESET(srst));
    // ==========================================
    // compare, verdict and timeout
    task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (uwr) n_uwr++;
        if (srst) n_srst++;
        if (cyc == 20000) begin
            n_errors++;
            wrap_up();
        end
    end
    // three code writes 00, 11, 10 over fixed upper bits
    task automatic seq3(input logic [7:0] hi);
        host.xfer(1'b1, 8'h10, hi);
        host.xfer(1'b1, 8'h10, hi | 8'h03);
        host.xfer(1'b1, 8'h10, hi | 8'h02);
    endtask
    // supply error pulse then settle
    task automatic sup_pulse(input int wait_cyc);
        @(posedge clk) sup <= 1'b1;
        repeat (5) @(posedge clk);
        sup <= 1'b0;
        repeat (wait_cyc) @(posedge clk);
    endtask
    // ==========================================
    // main sequence
    initial begin
        {rst_n, i2c, sup, st_req, st_done, n_errors, total_checks, cyc, n_uwr, n_srst} = '0;
        user = 32'h1234_5678;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        host.xfer(1'b0, 8'h10, 8'h00);
        chk("reset value", rdata, 8'h00);
        host.xfer(1'b1, 8'h21, 8'h5a);
        chk("forward echo", rdata, 8'h5a);
        chk("forward addr", uaddr, 8'h21);
        chk("forward data", udata, 8'h5a);
        host.xfer(1'b1, 8'h10, 8'h0b);
        chk("write echo", rdata, 8'h0b);
        host.xfer(1'b0, 8'h10, 8'h00);
        chk("read code", rdata, 8'h08);
        host.xfer(1'b1, 8'h10, 8'h08);
        host.xfer(1'b0, 8'h10, 8'h00);
        host.xfer(1'b1, 8'h10, 8'h0b);
        host.xfer(1'b1, 8'h10, 8'h0a);
        chk("read aborts sequence", rdis, 1'b1);
        host.xfer(1'b1, 8'h10, 8'h08);
        host.xfer(1'b1, 8'h10, 8'h0a);
        chk("mismatch abandons", rdis, 1'b1);
        seq3(8'h08);
        chk("reset write silent", silent, 1'b1);
        chk("reset write echo", rdata, 8'h0a);
        chk("soft reset done", rdis, 1'b0);
        @(posedge clk) st_req <= 1'b1;
        @(posedge clk) st_req <= 1'b0;
        repeat (3) @(posedge clk);
        chk("self-test unlocked", strun, 1'b1);
        host.xfer(1'b1, 8'h10, 8'h80);
        host.xfer(1'b1, 8'h10, 8'h09);
        chk("locked write", rdata, 8'h81);
        host.xfer(1'b1, 8'h10, 8'h00);
        chk("lock sticks", lock, 1'b1);
        chk("self-test stopped", strun, 1'b0);
        host.xfer(1'b1, 8'h21, 8'h55);
        chk("other write refused", rdata, 8'h00);
        chk("locked data kept", udata, 8'h5a);
        chk("code bits outside check", edc, 1'b0);
        @(posedge clk) user <= 32'h0;
        repeat (40) @(posedge clk);
        chk("corruption seen", edc, 1'b1);
        seq3(8'h80);
        chk("locked reset", lock, 1'b0);
        chk("check disarmed", edc, 1'b0);
        sup_pulse(0);
        host.xfer(1'b0, 8'h10, 8'h00);
        chk("silent while timer runs", silent, 1'b1);
        repeat (60) @(posedge clk);
        host.xfer(1'b0, 8'h10, 8'h00);
        chk("error code once", ecode, 1'b1);
        host.xfer(1'b0, 8'h10, 8'h00);
        chk("error code gone", ecode, 1'b0);
        chk("cleared by send", serr, 1'b0);
        host.xfer(1'b1, 8'h10, 8'h08);
        sup_pulse(60);
        chk("auto clear", serr, 1'b0);
        @(posedge clk) i2c <= 1'b1;
        sup_pulse(60);
        chk("held in two-wire mode", serr, 1'b1);
        host.xfer(1'b0, 8'h02, 8'h00);
        chk("status read clears", serr, 1'b0);
        chk("forwarded writes", 8'(n_uwr), 8'h01);
        chk("soft resets", 8'(n_srst), 8'h02);
        chk("answers missed", 8'(host.missed), 8'h00);
        wrap_up();
    end
endmodule // write_lock_reset_ctrl_tb
